/* File: dv/pllcs_chk.sv */
// port checker of the pll clock select block
`timescale 1ns/10ps
`default_nettype none
`include "pllcs_defines.svh"
module pllcs_chk
(
	input wire logic        clock,        // clock
	input wire logic        rst,          // reset
	input wire logic        psel,         // apb
	input wire logic        penable,      // apb
	input wire logic        pwrite,       // apb
	input wire logic [11:0] paddr,        // apb
	input wire logic [31:0] prdata,       // apb
	input wire logic        pready,       // apb
	input wire logic        pslverr,      // apb
	input wire logic        crystal_clk,  // source
	input wire logic        vco_clk,      // source
	input wire logic        base_clk_out, // output clock
	input wire logic        loopIrq,      // interrupt
	input wire logic        loopRun,      // loop on
	input wire logic        trackModeOut, // filter mode
	input wire logic  [3:0] fbDivide      // multiplier
);
	// ==========
	// helpers
	logic       xPrev;
	logic       vPrev;
	logic [2:0] sinceRise;
	logic       progRead;
	assign progRead = pready && !pwrite && paddr[11:2] == `PLLCS_PROG_IDX;
	// cycles since a raw source rise; saturating, so idle costs nothing
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			xPrev     <= 1'b0;
			vPrev     <= 1'b0;
			sinceRise <= 3'h7;
		end
		else
		begin
			xPrev     <= crystal_clk;
			vPrev     <= vco_clk;
			if ((crystal_clk && !xPrev) || (vco_clk && !vPrev))
				sinceRise <= 3'h0;
			else if (sinceRise != 3'h7)
				sinceRise <= sinceRise + 3'h1;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// ==========
	// assertions
	a_ready_follows: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unmapped: assert property (psel && !penable &&
		!(paddr[11:2] inside {`PLLCS_CTRL_IDX, `PLLCS_BW_IDX,
		`PLLCS_PROG_IDX}) |=> pslverr && pready)
		else $error("unmapped access not refused");
	a_fb_nonzero: assert property (!$past(rst) |-> fbDivide != 4'h0)
		else $error("feedback multiplier zero");
	a_fb_field: assert property (progRead |-> fbDivide ==
		((prdata[7:4] == 4'h0) ? 4'h1 : prdata[7:4]))
		else $error("multiplier differs from register");
	a_range_off: assert property (progRead && prdata[3:0] == 4'h0
		|-> !loopRun)
		else $error("loop runs with range zero");
	a_edge_source: assert property ($changed(base_clk_out)
		|-> sinceRise <= 3'h4)
		else $error("base clock moved without a source edge");
	a_track_off: assert property (!loopRun [*3] |-> !trackModeOut)
		else $error("tracking with loop off");
	cover property ($rose(loopIrq));
	cover property ($rose(trackModeOut));
	cover property (pslverr);
endmodule
`default_nettype wire

/* File: dv/pllcs_far.sv */
// far side model: crystal, vco and frequency error monitor
`timescale 1ns/10ps
`default_nettype none
module pllcs_far
#(
	parameter int XHALF = 40, // crystal half period in ns
	parameter int VHALF = 30  // vco half period in ns
)
(
	input  wire logic locked,        // bench: frequency inside all windows
	input  wire logic run,           // vco powered by the loop
	output logic      crystal_clk,   // crystal reference
	output logic      vco_clk,       // vco clock, still while unpowered
	output logic      inTrackTol,    // monitor level
	output logic      outUntrackTol, // monitor level
	output logic      inLockTol,     // monitor level
	output logic      outUnlockTol   // monitor level
);
	// ==========
	// clocks; odd offsets keep both unrelated to the system clock
	initial
	begin
		crystal_clk = 1'b0;
		#3;
		forever #XHALF crystal_clk = ~crystal_clk;
	end
	initial
	begin
		vco_clk = 1'b0;
		#7;
		forever #VHALF vco_clk = run ? ~vco_clk : 1'b0;
	end
	// ==========
	// monitor: both windows agree, no hysteresis band modelled
	assign inTrackTol    = locked;
	assign outUntrackTol = !locked;
	assign inLockTol     = locked;
	assign outUnlockTol  = !locked;
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench of the pll clock select block
`timescale 1ns/10ps
`default_nettype none
`include "pllcs_defines.svh"
module tb_top;
	localparam logic [11:0] A_CTRL = {`PLLCS_CTRL_IDX, 2'b00};
	localparam logic [11:0] A_BW   = {`PLLCS_BW_IDX, 2'b00};
	localparam logic [11:0] A_PROG = {`PLLCS_PROG_IDX, 2'b00};
	logic        clock, rst, psel, penable, pwrite, stopReq, locked;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, rerr, crystal_clk, vco_clk;
	logic        inTrackTol, outUntrackTol, inLockTol, outUnlockTol;
	logic        base_clk_out, loopIrq, loopRun, trackModeOut;
	logic  [3:0] fbDivide;
	logic  [7:0] p;
	int          n_errors, n_compared, seed;

	pllcs_top uut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .stopReq, .crystal_clk,
		.vco_clk, .inTrackTol, .outUntrackTol, .inLockTol, .outUnlockTol,
		.base_clk_out, .loopIrq, .loopRun, .trackModeOut, .fbDivide);
	pllcs_far far (.locked, .run(loopRun), .crystal_clk, .vco_clk,
		.inTrackTol, .outUntrackTol, .inLockTol, .outUnlockTol);

	// ==========
	// clock, 100 MHz
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic conclude();
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// zero multiplier code acts as one
	function automatic logic [3:0] fb_exp(input logic [7:0] v);
		return (v[7:4] == 4'h0) ? 4'h1 : v[7:4];
	endfunction

	// one apb transfer; request held until ready is seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		// ready, data and error are taken at the same rising edge
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		chk("pready", 32'(pready), 32'(1'b1));
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input string nm);
		xfer(1'b0, a, 8'h00);
		chk(nm, rdat, {24'h00_0000, e});
	endtask

	task automatic wait_n(input int k);
		repeat (k) @(negedge clock);
	endtask

	// time between two rises of the base clock, in ns
	task automatic per(input int e, input string nm);
		time t0;
		@(posedge base_clk_out);
		t0 = $time;
		@(posedge base_clk_out);
		chk(nm, 32'($time - t0), 32'(e));
	endtask

	// ==========
	// watchdog: the whole run needs some 600 cycles
	initial
	begin
		#400000;
		n_errors++;
		conclude();
	end

	// ==========
	// main sequence
	initial
	begin
		{rst, psel, penable, pwrite, stopReq, locked} = 6'b10_0000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		seed = $urandom(92);
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(A_CTRL, 8'h2f, "ctrl reset");
		rd(A_BW, 8'h00, "bw reset");
		rd(12'h07c, 8'h00, "unmapped");
		chk("slverr", 32'(rerr), 32'(1'b1));
		// programming codes: corners, then random
		for (int i = 0; i < 12; i++)
		begin
			p = (i == 0) ? 8'h00 : (i == 1) ? 8'hf0 : 8'($urandom);
			xfer(1'b1, A_PROG, p);
			rd(A_PROG, p, "prog");
			chk("fbDivide", 32'(fbDivide), 32'(fb_exp(p)));
			chk("loopRun", 32'(loopRun), 32'(p[3:0] != 4'h0));
		end
		xfer(1'b1, A_PROG, 8'h66);
		// manual mode
		xfer(1'b1, A_CTRL, 8'ha0);
		rd(A_CTRL, 8'h2f, "ctrl manual");
		xfer(1'b1, A_BW, 8'h20);
		locked <= 1'b1;
		wait_n(8);
		rd(A_BW, 8'h20, "bw manual");
		chk("track", 32'(trackModeOut), 32'(1'b1));
		chk("irq manual", 32'(loopIrq), 32'(1'b0));
		xfer(1'b1, A_BW, 8'h00);
		locked <= 1'b0;
		wait_n(8);
		chk("acquire", 32'(trackModeOut), 32'(1'b0));
		// automatic mode
		xfer(1'b1, A_BW, 8'h80);
		xfer(1'b1, A_CTRL, 8'ha0);
		rd(A_BW, 8'h80, "bw unlocked");
		locked <= 1'b1;
		wait_n(8);
		chk("irq lock", 32'(loopIrq), 32'(1'b1));
		chk("track auto", 32'(trackModeOut), 32'(1'b1));
		rd(A_BW, 8'he0, "bw locked");
		xfer(1'b1, A_BW, 8'h80);
		rd(A_BW, 8'he0, "bw read only");
		rd(A_CTRL, 8'hef, "ctrl flag");
		rd(A_CTRL, 8'haf, "ctrl cleared");
		wait_n(2);
		chk("irq cleared", 32'(loopIrq), 32'(1'b0));
		locked <= 1'b0;
		wait_n(8);
		chk("irq unlock", 32'(loopIrq), 32'(1'b1));
		rd(A_BW, 8'h80, "bw lost");
		xfer(1'b1, A_BW, 8'h00);
		wait_n(2);
		chk("irq off", 32'(loopIrq), 32'(1'b0));
		// interlocks, then software's manual start order
		xfer(1'b1, A_CTRL, 8'h00);
		xfer(1'b1, A_CTRL, 8'h10);
		rd(A_CTRL, 8'h0f, "select loop off");
		xfer(1'b1, A_CTRL, 8'h30);
		rd(A_CTRL, 8'h2f, "power and select");
		wait_n(20);
		xfer(1'b1, A_BW, 8'h20);
		wait_n(20);
		xfer(1'b1, A_CTRL, 8'h30);
		rd(A_CTRL, 8'h3f, "select vco");
		xfer(1'b1, A_CTRL, 8'h10);
		rd(A_CTRL, 8'h3f, "power kept");
		wait_n(60);
		per(120, "vco base period");
		xfer(1'b1, A_PROG, 8'h60);
		wait_n(60);
		per(160, "range zero period");
		xfer(1'b1, A_PROG, 8'h66);
		wait_n(60);
		per(120, "vco again");
		// held across one rising edge so the design samples it
		stopReq <= 1'b1;
		@(posedge clock);
		stopReq <= 1'b0;
		rd(A_CTRL, 8'h2f, "ctrl after stop");
		wait_n(60);
		per(160, "crystal period");
		conclude();
	end
endmodule

bind pllcs_top pllcs_chk chk (.clock, .rst, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .crystal_clk, .vco_clk,
	.base_clk_out, .loopIrq, .loopRun, .trackModeOut, .fbDivide);
`default_nettype wire

/* File: logic/pllcs_defines.svh */
// register map, field positions, reset values and counts of the pll clock select
`ifndef PLLCS_DEFINES_SVH
`define PLLCS_DEFINES_SVH

// register indices; byte address is four times the index
`define PLLCS_CTRL_IDX   10'h01c
`define PLLCS_BW_IDX     10'h01d
`define PLLCS_PROG_IDX   10'h01e

// loop control register fields
`define PLLCS_IRQEN_BIT  7
`define PLLCS_CHG_BIT    6
`define PLLCS_PWR_BIT    5
`define PLLCS_SRC_BIT    4
`define PLLCS_CTRL_FILL  4'hf

// bandwidth control register fields
`define PLLCS_AUTO_BIT   7
`define PLLCS_LOCK_BIT   6
`define PLLCS_CAPN_BIT   5

// reset values
`define PLLCS_PWR_RST    1'b1
`define PLLCS_PROG_RST   8'h66

// source edges waited on each side of a switch
`define PLLCS_SW_EDGES   2'h3

`endif

/* File: logic/pllcs_pkg.sv */
// types shared by the pll clock select logic
`default_nettype none
package pllcs_pkg;
	typedef enum logic [0:0]
	{
		PLLCS_SEL_RUN   = 1'b0,
		PLLCS_SEL_DRAIN = 1'b1
	} pllcs_sel_type;
endpackage
`default_nettype wire

/* File: logic/pllcs_top.sv */
// pll mode control, lock flags and glitch-free base clock selector
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pllcs_defines.svh"

module pllcs_top
	import pllcs_pkg::*;
(
	input  wire logic        clock,        // 100 MHz system clock
	input  wire logic        rst,          // async reset, active high
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction
	input  wire logic [11:0] paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error, unmapped address
	input  wire logic        stopReq,      // stop instruction executed
	input  wire logic        crystal_clk,  // crystal reference pin
	input  wire logic        vco_clk,      // vco clock pin
	input  wire logic        inTrackTol,   // monitor: inside tracking window
	input  wire logic        outUntrackTol,// monitor: outside untrack window
	input  wire logic        inLockTol,    // monitor: inside lock window
	input  wire logic        outUnlockTol, // monitor: outside unlock window
	output logic             base_clk_out, // selected clock divided by two
	output logic             loopIrq,      // loop interrupt request
	output logic             loopRun,      // loop enabled to the analog part
	output logic             trackModeOut, // filter mode, 1 tracking
	output logic       [3:0] fbDivide      // effective feedback multiplier
);

	// =========================================================
	// helpers
	// edge of a synchronised clock, seen once per source period
	function automatic logic riseEdge(input logic cur, input logic prev);
		riseEdge = cur & ~prev;
	endfunction

	// =========================================================
	// pin synchronisers
	logic [1:0] xSync_r;
	logic [1:0] vSync_r;
	logic [1:0] trkSync_r;
	logic [1:0] untSync_r;
	logic [1:0] lckSync_r;
	logic [1:0] unlSync_r;
	logic       xPrev_r;
	logic       vPrev_r;

	// two flops each; only the second stage is read by logic
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			xSync_r   <= 2'h0;
			vSync_r   <= 2'h0;
			trkSync_r <= 2'h0;
			untSync_r <= 2'h0;
			lckSync_r <= 2'h0;
			unlSync_r <= 2'h0;
			xPrev_r   <= 1'b0;
			vPrev_r   <= 1'b0;
		end
		else
		begin
			xSync_r   <= {xSync_r[0], crystal_clk};
			vSync_r   <= {vSync_r[0], vco_clk};
			trkSync_r <= {trkSync_r[0], inTrackTol};
			untSync_r <= {untSync_r[0], outUntrackTol};
			lckSync_r <= {lckSync_r[0], inLockTol};
			unlSync_r <= {unlSync_r[0], outUnlockTol};
			xPrev_r   <= xSync_r[1];
			vPrev_r   <= vSync_r[1];
		end
	end

	logic xEdge;
	logic vEdge;
	assign xEdge = riseEdge(xSync_r[1], xPrev_r);
	assign vEdge = riseEdge(vSync_r[1], vPrev_r);

	// =========================================================
	// apb decode
	logic       irqEn_r;
	logic       chgFlag_r;
	logic       pwrOn_r;
	logic       srcSel_r;
	logic       autoBw_r;
	logic       settled_r;
	logic       trackAuto_r;
	logic       manCapN_r;
	logic [7:0] prog_r;

	logic       setup;
	logic       wrEn;
	logic       rdEn;
	logic       hitCtrl;
	logic       hitBw;
	logic       hitProg;
	logic       hitAny;
	logic [9:0] regIdx;

	// zero wait states: the access phase ends at its first edge
	assign setup  = psel & ~penable;
	assign wrEn   = psel & penable & pwrite;
	assign rdEn   = psel & penable & ~pwrite;
	assign regIdx = paddr[11:2];

	// word decode, low address bits ignored
	always_comb
	begin
		hitCtrl = 1'b0;
		hitBw   = 1'b0;
		hitProg = 1'b0;
		if (regIdx == `PLLCS_CTRL_IDX)
			hitCtrl = 1'b1;
		else if (regIdx == `PLLCS_BW_IDX)
			hitBw = 1'b1;
		else if (regIdx == `PLLCS_PROG_IDX)
			hitProg = 1'b1;
	end
	assign hitAny = hitCtrl | hitBw | hitProg;

	// =========================================================
	// derived loop state
	logic rangeZero;
	logic loopOn;
	logic trackMode;
	logic settledVis;
	logic capNVis;

	assign rangeZero = (prog_r[3:0] == 4'h0);
	assign loopOn    = pwrOn_r & ~rangeZero;
	// automatic mode follows the detector, manual the stored bit
	assign trackMode = autoBw_r ? trackAuto_r : manCapN_r;
	assign capNVis   = trackMode;
	assign settledVis = autoBw_r & settled_r;

	// =========================================================
	// loop control register
	logic wrCtrl;
	logic newPwr;
	logic newSrc;
	logic pwrAllowed;
	logic pwrChange;

	assign wrCtrl = wrEn & hitCtrl;
	assign newPwr = pwdata[`PLLCS_PWR_BIT];
	assign newSrc = pwdata[`PLLCS_SRC_BIT];
	// clearing power is refused while the vco is selected
	assign pwrAllowed = newPwr | ~srcSel_r;
	assign pwrChange  = pwrAllowed & (newPwr != pwrOn_r);

	// power bit
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pwrOn_r <= `PLLCS_PWR_RST;
		else if (wrCtrl && pwrAllowed)
			pwrOn_r <= newPwr;
	end

	// source select; a write that also changes power leaves it alone
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			srcSel_r <= 1'b0;
		else if (stopReq)
			srcSel_r <= 1'b0;
		else if (wrCtrl && !pwrChange)
		begin
			if (!newSrc)
				srcSel_r <= 1'b0;
			else if (pwrOn_r && !rangeZero)
				srcSel_r <= 1'b1;
		end
	end

	// irq enable only writable in automatic mode
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			irqEn_r <= 1'b0;
		else if (wrCtrl && autoBw_r)
			irqEn_r <= pwdata[`PLLCS_IRQEN_BIT];
	end

	// =========================================================
	// bandwidth control and programming registers
	logic wrBw;
	assign wrBw = wrEn & hitBw;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			autoBw_r <= 1'b0;
		else if (wrBw)
			autoBw_r <= pwdata[`PLLCS_AUTO_BIT];
	end

	// manual bit kept while automatic mode runs, restored on return
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			manCapN_r <= 1'b0;
		else if (wrBw && !autoBw_r)
			manCapN_r <= pwdata[`PLLCS_CAPN_BIT];
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			prog_r <= `PLLCS_PROG_RST;
		else if (wrEn && hitProg)
			prog_r <= pwdata[7:0];
	end

	// =========================================================
	// lock detector, automatic mode
	// hysteresis: set inside the narrow window, clear outside the wide one
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			trackAuto_r <= 1'b0;
		else if (!loopOn)
			trackAuto_r <= 1'b0;
		else if (untSync_r[1])
			trackAuto_r <= 1'b0;
		else if (trkSync_r[1])
			trackAuto_r <= 1'b1;
	end

	logic settledNxt;
	always_comb
	begin
		settledNxt = settled_r;
		if (!loopOn || !autoBw_r)
			settledNxt = 1'b0;
		else if (unlSync_r[1])
			settledNxt = 1'b0;
		else if (lckSync_r[1])
			settledNxt = 1'b1;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			settled_r <= 1'b0;
		else
			settled_r <= settledNxt;
	end

	// change flag: a toggle in the read cycle still sets it
	logic toggle;
	assign toggle = autoBw_r & (settledNxt != settled_r);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			chgFlag_r <= 1'b0;
		else if (!autoBw_r)
			chgFlag_r <= 1'b0;
		else if (toggle)
			chgFlag_r <= 1'b1;
		else if (psel && penable && hitCtrl)
			chgFlag_r <= 1'b0;
	end

	// request follows flag and enable, silent in manual mode
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			loopIrq <= 1'b0;
		else
			loopIrq <= autoBw_r & irqEn_r & (chgFlag_r | toggle);
	end

	// =========================================================
	// apb read and answer
	logic [7:0] rdByte;
	always_comb
	begin
		rdByte = 8'h00;
		if (hitCtrl)
			rdByte = {irqEn_r & autoBw_r, chgFlag_r & autoBw_r,
				pwrOn_r, srcSel_r, `PLLCS_CTRL_FILL};
		else if (hitBw)
			rdByte = {autoBw_r, settledVis, capNVis, 5'h00};
		else if (hitProg)
			rdByte = prog_r;
	end

	// data is captured in setup so it is stable for the whole access
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= {24'h00_0000, rdByte};
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~hitAny;
		end
	end

	// =========================================================
	// base clock selector
	pllcs_sel_type selState_r;
	logic          curSrc_r;
	logic [1:0]    xCnt_r;
	logic [1:0]    vCnt_r;
	logic          wantSrc;
	logic          xDone;
	logic          vDone;

	assign wantSrc = srcSel_r & ~rangeZero;
	assign xDone   = (xCnt_r == `PLLCS_SW_EDGES);
	// a stopped vco must not hang the switch back to crystal
	assign vDone   = (vCnt_r == `PLLCS_SW_EDGES) | ~loopOn;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			selState_r <= PLLCS_SEL_RUN;
			curSrc_r   <= 1'b0;
			xCnt_r     <= 2'h0;
			vCnt_r     <= 2'h0;
		end
		else
		begin
			case (selState_r)
				PLLCS_SEL_RUN:
				begin
					xCnt_r <= 2'h0;
					vCnt_r <= 2'h0;
					if (wantSrc != curSrc_r)
						selState_r <= PLLCS_SEL_DRAIN;
				end
				PLLCS_SEL_DRAIN:
				begin
					if (xEdge && !xDone)
						xCnt_r <= xCnt_r + 2'h1;
					if (vEdge && !vDone)
						vCnt_r <= vCnt_r + 2'h1;
					if (xDone && vDone)
					begin
						curSrc_r   <= wantSrc;
						selState_r <= PLLCS_SEL_RUN;
					end
				end
				default:
					selState_r <= PLLCS_SEL_RUN;
			endcase
		end
	end

	// divide by two, held still while draining
	logic srcEdge;
	assign srcEdge = curSrc_r ? vEdge : xEdge;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			base_clk_out <= 1'b0;
		else if (selState_r == PLLCS_SEL_RUN && srcEdge)
			base_clk_out <= ~base_clk_out;
	end

	// =========================================================
	// outputs to the analog loop
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			loopRun      <= 1'b0;
			trackModeOut <= 1'b0;
			fbDivide     <= 4'h0;
		end
		else
		begin
			loopRun      <= loopOn;
			trackModeOut <= trackMode & loopOn;
			fbDivide     <= (prog_r[7:4] == 4'h0) ? 4'h1 : prog_r[7:4];
		end
	end

endmodule
`default_nettype wire
